//--- logic/fws_pkg.sv
// Package for the flash write/suspend controller: register map, fields, states.
// Assumes a 16-bit register port on the system clock, one bank of eight sectors.
package fws_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [23:0] ADDR_CTRL_HIGH = 24'h080002; // write_control_high
   localparam logic [23:0] ADDR_SECTOR = 24'h080004;    // sector_select_status
   localparam logic [23:0] ADDR_BANK = 24'h080006;      // bank_status
   localparam logic [23:0] ADDR_IRQ_STAT = 24'h080020;
   localparam logic [23:0] ADDR_IRQ_MASK = 24'h080022;
   localparam logic [23:0] ADDR_STATUS = 24'h080024;    // busy, error, suspended flags
   // ----------------------------------------
   // Field positions and resets
   // ----------------------------------------
   localparam int BIT_START = 15;
   localparam int BIT_SUSPEND_REQUEST = 14;
   localparam int BIT_WPG = 13;
   localparam int BIT_DOUBLE_WORD_PROGRAM_SELECT = 12;
   localparam int BIT_SER = 11;
   localparam int BIT_BANK = 8;
   localparam int NUM_SECTORS = 8;
   localparam logic [15:0] RST_REG = 16'h0000;
   localparam int OP_CYCLES_W = 16;
   localparam logic [15:0] PROG_CYCLES = 16'h0020;
   localparam logic [15:0] ERASE_CYCLES = 16'h0100;
   // Interrupt event bits
   localparam int EV_DONE = 0;
   localparam int EV_SUSPEND_REQUEST = 1;
   localparam int EV_REJECT = 2;
   localparam int EV_TRAP = 3;
   localparam int NUM_EV = 4;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PROG = 3'b001,
      ST_ERASE = 3'b010,
      ST_PSUSP = 3'b011,
      ST_ESUSP = 3'b100,
      ST_EPROG = 3'b101
   } fws_state_e;

   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } fws_req_s;

   typedef struct packed {
      logic done;
      logic error;
   } fws_array_s;
endpackage

//--- logic/fws_flash_write_suspend_control.sv
// Control and status of the single-bank flash program/erase controller.
// Assumes an array engine that reports done/error per operation; register port is synchronous.
// Functional notes
// R01: suspend halts op, returns bank to read
// R02: program suspend allows reads and program resume
// R03: erase suspend allows programs; those unsuspendable
// R04: resume by start plus suspended op select
// R05: software never starts while suspend set
// R06: start launches op; cleared at end/suspend
// R07: start ignored while error flag high
// R08: writing zero to start does nothing
// R09: software selects sectors before erase
// R10: sector status bits set during erase
// R11: clean end clears sector status bits
// R12: bank status tracks erase, cleared on success
// R13: status with error means erase error
// R14: status with suspend means erase suspended
// R15: busy bank reads trap, writes ignored
// R16: software sets exactly one operation select
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module fws_flash_write_suspend_control
   import fws_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire fws_req_s regReq,
   output logic [15:0] regRdata,
   input wire logic errorFlag,
   input wire fws_array_s arrayResp,
   input wire logic arrayRead,
   input wire logic arrayWrite,
   output logic arrayTrap,
   output logic arrayWriteOk,
   output logic bankBusy,
   output logic [2:0] opSelect,
   output logic irq
);
   fws_state_e state_ff;
   fws_state_e nxt_state;
   logic start_ff, suspend_request_ff, wpg_ff, double_word_program_select_ff, ser_ff;
   logic [NUM_SECTORS-1:0] sectors_ff;
   logic bankStat_ff;
   logic [OP_CYCLES_W-1:0] cnt_ff;
   logic [NUM_EV-1:0] irqStat_ff, irqMask_ff, events;
   logic [15:0] ctrlWord;
   logic wrCtrl, setStart, anySel, endOk, endErr, opEnd, suspNow, reject;

   function automatic logic hit(input fws_req_s r, input logic [23:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   assign wrCtrl = hit(regReq, ADDR_CTRL_HIGH);
   assign anySel = regReq.wdata[BIT_WPG] | regReq.wdata[BIT_DOUBLE_WORD_PROGRAM_SELECT] | regReq.wdata[BIT_SER];
   // Start only on a written one; zero leaves it alone [R08]; error blocks it [R07]
   assign setStart = wrCtrl && regReq.wdata[BIT_START] && !errorFlag && !start_ff;
   assign opEnd = arrayResp.done || (cnt_ff == '0 && (state_ff == ST_PROG || state_ff == ST_ERASE
                  || state_ff == ST_EPROG));
   assign endErr = opEnd && arrayResp.error;
   assign endOk = opEnd && !arrayResp.error;
   // Erase-suspend programs cannot be suspended [R03]
   assign suspNow = suspend_request_ff && (state_ff == ST_PROG || state_ff == ST_ERASE); // [R01]

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Next state of the sequencer
   always_comb begin
      nxt_state = state_ff;
      reject = 1'b0;
      unique case (state_ff)
         ST_IDLE: begin
            if (setStart && anySel)
               nxt_state = regReq.wdata[BIT_SER] ? ST_ERASE : ST_PROG;
         end
         ST_PROG, ST_ERASE: begin
            if (suspNow) begin
               nxt_state = (state_ff == ST_PROG) ? ST_PSUSP : ST_ESUSP; // [R01]
            end else if (opEnd) nxt_state = ST_IDLE;
         end
         ST_PSUSP: begin
            // Only the program resume is taken [R02] [R04]
            if (setStart && (regReq.wdata[BIT_WPG] == wpg_ff) && (regReq.wdata[BIT_DOUBLE_WORD_PROGRAM_SELECT] == double_word_program_select_ff)
                && !regReq.wdata[BIT_SER])
               nxt_state = ST_PROG;
            else if (setStart) reject = 1'b1; // [R02]
         end
         ST_ESUSP: begin
            if (setStart && regReq.wdata[BIT_SER]) nxt_state = ST_ERASE; // [R04]
            else if (setStart && (regReq.wdata[BIT_WPG] || regReq.wdata[BIT_DOUBLE_WORD_PROGRAM_SELECT]))
               nxt_state = ST_EPROG; // [R03]
            else if (setStart) reject = 1'b1;
         end
         ST_EPROG: begin
            if (opEnd) nxt_state = ST_ESUSP;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Sequencer state
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) state_ff <= ST_IDLE;
      else state_ff <= nxt_state;
   end

   // Operation timer; engine done may end it earlier
   // Shared timer: a program inside erase suspend reuses it, so a resumed erase gets only what is left
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) cnt_ff <= '0;
      else if (nxt_state != state_ff && (nxt_state == ST_PROG || nxt_state == ST_EPROG))
         cnt_ff <= PROG_CYCLES;
      else if (state_ff != ST_ERASE && nxt_state == ST_ERASE && state_ff != ST_ESUSP)
         cnt_ff <= ERASE_CYCLES;
      else if (cnt_ff != '0 && (state_ff == ST_PROG || state_ff == ST_ERASE || state_ff == ST_EPROG))
         cnt_ff <= cnt_ff - 1'b1;
   end

   // ----------------------------------------
   // Control register bits
   // ----------------------------------------
   // Start: set by software, cleared only by the controller [R06] [R08]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) start_ff <= 1'b0;
      else if (nxt_state == ST_IDLE || nxt_state == ST_PSUSP || nxt_state == ST_ESUSP) start_ff <= 1'b0; // [R06]
      else if (nxt_state != state_ff) start_ff <= 1'b1; // [R06]
   end

   // Suspend request and selects are plain software bits; selects auto-clear at end, except after a program in erase suspend, which reselects erase
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         suspend_request_ff <= 1'b0;
         wpg_ff <= 1'b0;
         double_word_program_select_ff <= 1'b0;
         ser_ff <= 1'b0;
      // In program suspend the selects must keep the suspended op for its resume [R02]
      end else if (wrCtrl && !bankBusy && state_ff != ST_PSUSP) begin
         suspend_request_ff <= regReq.wdata[BIT_SUSPEND_REQUEST];
         wpg_ff <= regReq.wdata[BIT_WPG]; // [R16]
         double_word_program_select_ff <= regReq.wdata[BIT_DOUBLE_WORD_PROGRAM_SELECT];
         ser_ff <= regReq.wdata[BIT_SER];
      end else if (wrCtrl) begin
         suspend_request_ff <= regReq.wdata[BIT_SUSPEND_REQUEST]; // Suspend must be writable while busy
      end else if (opEnd && state_ff == ST_EPROG) begin
         wpg_ff <= 1'b0;
         double_word_program_select_ff <= 1'b0;
         ser_ff <= 1'b1; // Erase stays selected for its resume
      end else if (opEnd && !suspNow) begin
         wpg_ff <= 1'b0;
         double_word_program_select_ff <= 1'b0;
         ser_ff <= 1'b0;
      end
   end

   // Sector status: software selection, then hardware status [R09] [R10] [R11]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) sectors_ff <= RST_REG[NUM_SECTORS-1:0];
      else if (endOk && state_ff != ST_EPROG) sectors_ff <= '0; // [R11]
      else if (hit(regReq, ADDR_SECTOR) && !bankBusy) sectors_ff <= regReq.wdata[NUM_SECTORS-1:0];
   end

   // Bank status set during erase, cleared on clean finish [R12]
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) bankStat_ff <= 1'b0;
      else if (state_ff == ST_ERASE && endOk && !suspNow) bankStat_ff <= 1'b0; // [R12]
      else if (state_ff == ST_ERASE) bankStat_ff <= 1'b1; // [R12]
   end

   // ----------------------------------------
   // Bank access gating
   // ----------------------------------------
   assign bankBusy = (state_ff == ST_PROG) || (state_ff == ST_ERASE) || (state_ff == ST_EPROG); // [R01]
   assign arrayTrap = bankBusy && arrayRead; // [R15]
   assign arrayWriteOk = !bankBusy && arrayWrite; // [R15]
   assign opSelect = {ser_ff, double_word_program_select_ff, wpg_ff};

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign events = {arrayTrap, reject, suspNow, opEnd};
   // Set wins over a same-cycle clear
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) irqStat_ff <= '0;
      else if (hit(regReq, ADDR_IRQ_STAT)) irqStat_ff <= (irqStat_ff & ~regReq.wdata[NUM_EV-1:0]) | events;
      else irqStat_ff <= irqStat_ff | events;
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) irqMask_ff <= '0;
      else if (hit(regReq, ADDR_IRQ_MASK)) irqMask_ff <= regReq.wdata[NUM_EV-1:0];
   end
   assign irq = |(irqStat_ff & irqMask_ff);

   // ----------------------------------------
   // Read port, data one cycle after strobe
   // ----------------------------------------
   assign ctrlWord = {start_ff, suspend_request_ff, wpg_ff, double_word_program_select_ff, ser_ff, 11'h000};
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) regRdata <= RST_REG;
      else if (regReq.rd) begin
         unique case (regReq.addr)
            ADDR_CTRL_HIGH: regRdata <= ctrlWord;
            ADDR_SECTOR: regRdata <= {8'h00, sectors_ff}; // [R13] [R14] meaning with error/suspend
            ADDR_BANK: regRdata <= {7'h00, bankStat_ff, 8'h00};
            ADDR_IRQ_STAT: regRdata <= {12'h000, irqStat_ff};
            ADDR_IRQ_MASK: regRdata <= {12'h000, irqMask_ff};
            ADDR_STATUS: regRdata <= {12'h000, state_ff == ST_ESUSP, state_ff == ST_PSUSP, errorFlag, bankBusy};
            default: regRdata <= RST_REG;
         endcase
      end else regRdata <= RST_REG;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   suspend_request_busy_a: assert property (@(posedge clk_sys) disable iff (!arst_n) suspNow |=> !bankBusy && !start_ff) // [R01]
      else $error("suspend did not release bank");
   psusp_rej_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state_ff == ST_PSUSP && setStart && regReq.wdata[BIT_SER]) |=> state_ff == ST_PSUSP) // [R02]
      else $error("program suspend took other op");
   eprog_nosusp_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      state_ff == ST_EPROG && !opEnd |=> state_ff == ST_EPROG) // [R03]
      else $error("erase-suspend program was suspended");
   err_block_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state_ff == ST_IDLE && errorFlag) |=> state_ff == ST_IDLE) // [R07]
      else $error("start accepted with error");
   start_end_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state_ff == ST_PROG && opEnd && !suspNow) |=> !start_ff && state_ff == ST_IDLE) // [R06]
      else $error("start not cleared at end");
   sector_clr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (endOk && state_ff == ST_ERASE) |=> sectors_ff == '0) // [R11]
      else $error("sectors not cleared");
   bank_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state_ff == ST_ERASE && !opEnd) |=> bankStat_ff) // [R12]
      else $error("bank status not set");
   trap_busy_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      arrayRead && bankBusy |-> arrayTrap && !arrayWriteOk) // [R15]
      else $error("busy read not trapped");
   // Start bit: launched only by a written one, held until end or suspend
   zero_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R08]
      (wrCtrl && !regReq.wdata[BIT_START] && state_ff == ST_IDLE) |=> state_ff == ST_IDLE)
      else $error("zero start launched an operation");
   start_launch_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R06]
      (state_ff == ST_IDLE && setStart && anySel) |=> bankBusy && start_ff)
      else $error("start did not launch operation");
   start_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R08]
      (start_ff && bankBusy && !opEnd && !suspNow) |=> start_ff)
      else $error("start cleared while running");
   suspend_request_state_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R01]
      suspNow |=> (state_ff == ST_PSUSP || state_ff == ST_ESUSP))
      else $error("suspend did not reach suspend state");
   // Suspend states: what is accepted and what is refused
   psusp_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R02]
      (state_ff == ST_PSUSP && !setStart) |=> state_ff == ST_PSUSP)
      else $error("program suspend left without start");
   reject_ev_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R02]
      (state_ff == ST_PSUSP && reject) |=> irqStat_ff[EV_REJECT])
      else $error("refused op not flagged");
   psusp_resume_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R04]
      (state_ff == ST_PSUSP && setStart && regReq.wdata[BIT_WPG] == wpg_ff && regReq.wdata[BIT_DOUBLE_WORD_PROGRAM_SELECT] == double_word_program_select_ff
      && !regReq.wdata[BIT_SER]) |=> state_ff == ST_PROG)
      else $error("program resume not taken");
   esusp_prog_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R03]
      (state_ff == ST_ESUSP && setStart && !regReq.wdata[BIT_SER] && anySel) |=> state_ff == ST_EPROG)
      else $error("program in erase suspend not taken");
   esusp_resume_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R04]
      (state_ff == ST_ESUSP && setStart && regReq.wdata[BIT_SER]) |=> state_ff == ST_ERASE)
      else $error("erase resume not taken");
   err_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R07]
      (state_ff == ST_PSUSP && errorFlag) |=> state_ff == ST_PSUSP)
      else $error("resume accepted with error");
   // Status bits: kept on error, cleared on clean end, bank status set while erase is suspended
   sector_err_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R13]
      (endErr && state_ff == ST_ERASE) |=> sectors_ff == $past(sectors_ff))
      else $error("sector status lost on error");
   bank_err_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R13]
      (endErr && state_ff == ST_ERASE) |=> bankStat_ff)
      else $error("bank status lost on error");
   bank_clr_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R12]
      (state_ff == ST_ERASE && endOk && !suspNow) |=> !bankStat_ff)
      else $error("bank status not cleared");
   esusp_bank_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R14]
      state_ff == ST_ESUSP |-> bankStat_ff)
      else $error("bank status low in erase suspend");
   // Bank gating while the array is busy or free
   busy_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R15]
      arrayWrite && bankBusy |-> !arrayWriteOk)
      else $error("busy write not ignored");
   idle_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R15]
      arrayWrite && !bankBusy |-> arrayWriteOk)
      else $error("free write not passed");
   // Main scenarios: suspend of erase, program inside it, program resume, refusal
   erase_cov: cover property (@(posedge clk_sys) disable iff (!arst_n) state_ff == ST_ERASE ##1 state_ff == ST_ESUSP);
   eprog_cov: cover property (@(posedge clk_sys) disable iff (!arst_n) state_ff == ST_EPROG ##1 state_ff == ST_ESUSP);
   resume_cov: cover property (@(posedge clk_sys) disable iff (!arst_n) state_ff == ST_PSUSP ##1 state_ff == ST_PROG);
   reject_cov: cover property (@(posedge clk_sys) disable iff (!arst_n) state_ff == ST_PSUSP && reject);
endmodule // fws_flash_write_suspend_control

//--- verification/fws_tb.sv
// Self-checking bench for the flash write/suspend controller.
// Assumes the design package and module are compiled first; bench drives every port itself.
`timescale 1ns/1ps
module tb;
   import fws_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   fws_req_s regReq = '0;
   fws_array_s arrayResp = '0;
   logic errorFlag = 1'b0;
   logic arrayRead = 1'b0;
   logic arrayWrite = 1'b0;
   logic [15:0] regRdata;
   logic arrayTrap, arrayWriteOk, bankBusy, irq;
   logic [2:0] opSelect;
   logic [15:0] rdVal;
   int fails = 0;
   int num_checks = 0;
   // ----------------------------------------
   // Clock, design instance
   // ----------------------------------------
   always #10 clk_sys = ~clk_sys;
   fws_flash_write_suspend_control dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .regReq(regReq),
      .regRdata(regRdata), .errorFlag(errorFlag), .arrayResp(arrayResp), .arrayRead(arrayRead),
      .arrayWrite(arrayWrite), .arrayTrap(arrayTrap), .arrayWriteOk(arrayWriteOk),
      .bankBusy(bankBusy), .opSelect(opSelect), .irq(irq));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Four-state compare so an unknown never passes
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Strobe set right after an edge, stands for one sampling edge; outputs read 1 ns later
   task automatic wr(input logic [23:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regReq <= {a, d, 2'b10};
      @(posedge clk_sys);
      regReq <= '0;
      #1;
   endtask
   task automatic rd(input logic [23:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      regReq <= {a, 16'h0000, 2'b01};
      @(posedge clk_sys);
      regReq <= '0;
      #1;
      d = regRdata;
   endtask
   task automatic rdChk(input logic [23:0] a, input logic [15:0] exp);
      logic [15:0] v;
      rd(a, v);
      check(v, exp);
   endtask
   // Engine end pulse; error level travels with it
   task automatic finish(input logic err);
      @(posedge clk_sys);
      arrayResp <= '{done: 1'b1, error: err};
      @(posedge clk_sys);
      arrayResp <= '0;
      #1;
   endtask
   // Bounded wait for the bank to return to read mode
   task automatic waitIdle();
      int n;
      for (n = 0; n < 400 && bankBusy !== 1'b0; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (bankBusy !== 1'b0) begin
         fails++;
         conclude();
      end
   endtask
   function automatic logic [15:0] bit1(input logic b);
      return {15'h0000, b};
   endfunction
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk_sys);
      #1 arst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      // Reset values and an unmapped read
      rdChk(ADDR_CTRL_HIGH, RST_REG);
      rdChk(ADDR_SECTOR, RST_REG);
      rdChk(ADDR_BANK, RST_REG);
      rdChk(24'h080030, 16'h0000);
      check(bit1(irq), 16'h0000);
      // Select only: no launch without start
      wr(ADDR_CTRL_HIGH, 16'h2000);
      check(bit1(bankBusy), 16'h0000);
      check({13'h0000, opSelect}, 16'h0001);
      // Word program, start write of zero, busy-bank write, engine done
      wr(ADDR_CTRL_HIGH, 16'ha000);
      check(bit1(bankBusy), 16'h0001);
      wr(ADDR_CTRL_HIGH, 16'h2000);
      check(bit1(bankBusy), 16'h0001);
      rdChk(ADDR_CTRL_HIGH, 16'ha000);
      arrayWrite <= 1'b1;
      #1 check(bit1(arrayWriteOk), 16'h0000);
      finish(1'b0);
      check(bit1(bankBusy), 16'h0000);
      check(bit1(arrayWriteOk), 16'h0001);
      arrayWrite <= 1'b0;
      check({13'h0000, opSelect}, 16'h0000);
      rd(ADDR_CTRL_HIGH, rdVal);
      check(rdVal & 16'h8000, 16'h0000);
      // Done event: raise, mask, clear
      rdChk(ADDR_IRQ_STAT, 16'h0001);
      check(bit1(irq), 16'h0000);
      wr(ADDR_IRQ_MASK, 16'h000f);
      check(bit1(irq), 16'h0001);
      wr(ADDR_IRQ_MASK, 16'h0000);
      wr(ADDR_IRQ_STAT, 16'h0001);
      rdChk(ADDR_IRQ_STAT, 16'h0000);
      check(bit1(irq), 16'h0000);
      // Timer end with no engine pulse
      wr(ADDR_CTRL_HIGH, 16'h9000);
      check({13'h0000, opSelect}, 16'h0002);
      waitIdle();
      // Start refused while error flag high
      errorFlag <= 1'b1;
      wr(ADDR_CTRL_HIGH, 16'ha000);
      check(bit1(bankBusy), 16'h0000);
      errorFlag <= 1'b0;
      // Program suspend, refused other op, resume
      wr(ADDR_CTRL_HIGH, 16'ha000);
      arrayRead <= 1'b1;
      #1 check(bit1(arrayTrap), 16'h0001);
      wr(ADDR_CTRL_HIGH, 16'h6000);
      @(posedge clk_sys);
      #1;
      check(bit1(bankBusy), 16'h0000);
      check(bit1(arrayTrap), 16'h0000);
      arrayRead <= 1'b0;
      rdChk(ADDR_STATUS, 16'h0004);
      rd(ADDR_CTRL_HIGH, rdVal);
      check(rdVal & 16'h8000, 16'h0000);
      wr(ADDR_CTRL_HIGH, 16'h2000);
      wr(ADDR_CTRL_HIGH, 16'h9000);
      check(bit1(bankBusy), 16'h0000);
      rd(ADDR_IRQ_STAT, rdVal);
      check(rdVal & 16'h0004, 16'h0004);
      wr(ADDR_CTRL_HIGH, 16'ha000);
      check(bit1(bankBusy), 16'h0001);
      finish(1'b0);
      check(bit1(bankBusy), 16'h0000);
      // Erase with suspend, program inside suspend, resume, clean end
      wr(ADDR_SECTOR, 16'h0005);
      wr(ADDR_CTRL_HIGH, 16'h0800);
      wr(ADDR_CTRL_HIGH, 16'h8800);
      check(bit1(bankBusy), 16'h0001);
      rdChk(ADDR_SECTOR, 16'h0005);
      rdChk(ADDR_BANK, 16'h0100);
      wr(ADDR_CTRL_HIGH, 16'h4800);
      @(posedge clk_sys);
      #1;
      check(bit1(bankBusy), 16'h0000);
      rdChk(ADDR_STATUS, 16'h0008);
      rdChk(ADDR_SECTOR, 16'h0005);
      rdChk(ADDR_BANK, 16'h0100);
      wr(ADDR_CTRL_HIGH, 16'h2000);
      wr(ADDR_CTRL_HIGH, 16'ha000);
      check(bit1(bankBusy), 16'h0001);
      wr(ADDR_CTRL_HIGH, 16'h6000);
      check(bit1(bankBusy), 16'h0001);
      @(posedge clk_sys);
      #1;
      check(bit1(bankBusy), 16'h0001);
      finish(1'b0);
      check(bit1(bankBusy), 16'h0000);
      wr(ADDR_CTRL_HIGH, 16'h0800);
      wr(ADDR_CTRL_HIGH, 16'h8800);
      check(bit1(bankBusy), 16'h0001);
      finish(1'b0);
      rdChk(ADDR_SECTOR, 16'h0000);
      rdChk(ADDR_BANK, 16'h0000);
      // Erase ending in error keeps status bits
      wr(ADDR_SECTOR, 16'h0080);
      wr(ADDR_CTRL_HIGH, 16'h0800);
      wr(ADDR_CTRL_HIGH, 16'h8800);
      finish(1'b1);
      errorFlag <= 1'b1;
      rdChk(ADDR_SECTOR, 16'h0080);
      rdChk(ADDR_BANK, 16'h0100);
      conclude();
   end
endmodule // tb
